// [core/ratio_divider.sv]
// Power-of-two output divider with synchronised enable, start-up hold and APB registers.
// Operation
// - Four-bit select code drives ratio and float.
// - Code top bit is the disable float bit.
// - Disabled output: low, or floated when bit set.
// - Master clock divided by one to 128.
// - Codes mirror about midpoint, 0 and 15 give one.
// - Enable high drives divided clock on output.
// - Enable low disables output at once, asynchronously.
// - Re-enable aligns to master clock, no slivers.
// - Start-up waits for a stable select code.
// - Master clock no faster than 1 MHz.
// - Enable alignment delay bounded by one master period.
// - Code changes applied only when stable, glitchless.
// - Output floats for the start-up interval.
// - First pulse preceded by a low interval.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "ratio_divider_regs.svh"

module ratio_divider
	import ratio_divider_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] ratio_select_code,
	input wire logic oe_pin,
	output logic out_level,
	output logic out_drive_n
);

	localparam int MIN_HALF = `MIN_HALF_CYCLES;

	logic [15:0] half_period_reg;
	logic [9:0] start_len_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [3:0] code_s1_reg, code_s2_reg, code_s3_reg;
	logic oe_s1_reg, oe_s2_reg, oe_s3_reg;
	logic oe_level_reg;
	logic [15:0] hcnt_reg;
	logic master_phase_reg;
	code_t cand_reg;
	code_t active_code_reg;
	logic [4:0] stab_cnt_reg;
	logic code_valid_reg;
	logic [9:0] start_cnt_reg;
	div_state_t state_reg;
	logic [2:0] cur_exp_reg;
	logic [7:0] dcnt_reg;
	logic out_reg;
	logic [15:0] half_lim;
	logic half_tick;
	logic master_rise;
	logic [2:0] new_exp;
	logic [7:0] cur_lim;
	logic [7:0] new_lim;
	logic start_done;
	logic float_bit;
	logic setup_phase;
	logic access_wr;
	logic addr_hit;

	// Map a select code to the exponent of its ratio.
	function automatic logic [2:0] code_exp(input code_t code);
		code_exp = code[3] ? ~code[2:0] : code[2:0];
	endfunction

	// APB decode; the slave never inserts wait states.
	assign setup_phase = psel & ~penable;
	assign access_wr = psel & penable & pwrite;
	assign addr_hit = (paddr == `OFF_HALF_PERIOD) || (paddr == `OFF_START_LEN) ||
		(paddr == `OFF_STATUS);
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg & psel & penable;

	// Writable registers; the status word is read only and writes to it are dropped.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_period_reg <= `HALF_PERIOD_RST;
			start_len_reg <= `START_LEN_RST;
		end else if (access_wr && paddr == `OFF_HALF_PERIOD) begin
			half_period_reg <= pwdata[15:0];
		end else if (access_wr && paddr == `OFF_START_LEN) begin
			start_len_reg <= pwdata[9:0];
		end
	end

	// Read data and error are captured in the setup cycle so they come from flip-flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (setup_phase) begin
			pslverr_reg <= ~addr_hit;
			unique case (paddr)
				`OFF_HALF_PERIOD: prdata_reg <= {16'h0000, half_period_reg};
				`OFF_START_LEN: prdata_reg <= {22'h000000, start_len_reg};
				`OFF_STATUS: prdata_reg <= {24'h000000, out_level, (state_reg == ST_RUN),
					code_valid_reg, start_done, active_code_reg};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Pin synchronisers; a change counts once the second and third stages agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_s1_reg <= 4'h0;
			code_s2_reg <= 4'h0;
			code_s3_reg <= 4'h0;
			oe_s1_reg <= 1'b0;
			oe_s2_reg <= 1'b0;
			oe_s3_reg <= 1'b0;
			oe_level_reg <= 1'b0;
		end else begin
			code_s1_reg <= ratio_select_code;
			code_s2_reg <= code_s1_reg;
			code_s3_reg <= code_s2_reg;
			oe_s1_reg <= oe_pin;
			oe_s2_reg <= oe_s1_reg;
			oe_s3_reg <= oe_s2_reg;
			if (oe_s2_reg == oe_s3_reg) begin
				oe_level_reg <= oe_s3_reg;
			end
		end
	end

	// Master oscillator model: half periods are clamped so the master never exceeds its limit.
	// master rate clamp
	assign half_lim = (half_period_reg < 16'(MIN_HALF)) ? 16'(MIN_HALF) : half_period_reg;
	assign half_tick = (hcnt_reg >= half_lim - 16'h0001);
	assign master_rise = half_tick & master_phase_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcnt_reg <= 16'h0000;
			master_phase_reg <= 1'b0;
		end else if (half_tick) begin
			hcnt_reg <= 16'h0000;
			master_phase_reg <= ~master_phase_reg;
		end else begin
			hcnt_reg <= hcnt_reg + 16'h0001;
		end
	end

	// Select code filter: a code must hold for a run of master periods before it is used,
	// which keeps a slowly settling pin from walking through intermediate codes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cand_reg <= 4'h0;
			stab_cnt_reg <= 5'h00;
			active_code_reg <= 4'h0;
			code_valid_reg <= 1'b0;
		end else if (master_rise && code_s2_reg == code_s3_reg) begin
			if (cand_reg != code_s3_reg) begin
				cand_reg <= code_s3_reg;
				stab_cnt_reg <= 5'h00;
			end else if (stab_cnt_reg < `CODE_STABLE_TICKS) begin
				stab_cnt_reg <= stab_cnt_reg + 5'h01;
			end else begin
				active_code_reg <= cand_reg;
				code_valid_reg <= 1'b1;
			end
		end
	end

	assign new_exp = code_exp(active_code_reg);
	assign float_bit = active_code_reg[3];
	assign new_lim = 8'((9'h001 << new_exp) - 9'h001);
	assign cur_lim = 8'((9'h001 << cur_exp_reg) - 9'h001);
	assign start_done = (state_reg != ST_START);

	// Start-up counter in master periods.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_cnt_reg <= 10'h000;
		end else if (master_rise && state_reg == ST_START && start_cnt_reg < start_len_reg) begin
			start_cnt_reg <= start_cnt_reg + 10'h001;
		end
	end

	// Output state machine and divider.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_START;
			cur_exp_reg <= 3'h0;
			dcnt_reg <= 8'h00;
			out_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_START: begin
					if (master_rise && start_cnt_reg >= start_len_reg && code_valid_reg) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					out_reg <= 1'b0;
					if (oe_level_reg) begin
						state_reg <= ST_ALIGN;
					end
				end
				ST_ALIGN: begin
					if (!oe_level_reg) begin
						state_reg <= ST_IDLE;
					end else if (master_rise) begin
						state_reg <= ST_RUN;
						cur_exp_reg <= new_exp;
						out_reg <= 1'b0;
						// low one master period, or half output period
						dcnt_reg <= (new_exp >= 3'h2) ? new_lim - 8'h01 : 8'h00;
					end
				end
				ST_RUN: begin
					if (!oe_level_reg) begin
						state_reg <= ST_IDLE;
						out_reg <= 1'b0;
					end else if (half_tick) begin
						if (dcnt_reg >= cur_lim) begin
							dcnt_reg <= 8'h00;
							out_reg <= ~out_reg;
							// ratio swaps only at a period end
							if (out_reg) begin
								cur_exp_reg <= new_exp;
							end
						end else begin
							dcnt_reg <= dcnt_reg + 8'h01;
						end
					end
				end
			endcase
		end
	end

	// The raw enable pin gates the pin so disabling needs no clock edge; re-enabling
	// still waits for the synchronised path, so the raw pin can only cut pulses short.
	// drive divided clock when enabled
	assign out_level = oe_pin & (state_reg == ST_RUN) & out_reg;
	assign out_drive_n = ~start_done | (float_bit & ~(oe_pin & (state_reg == ST_RUN)));

	// Helper counter of cycles spent waiting for alignment.
	logic [17:0] align_cnt_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			align_cnt_reg <= 18'h00000;
		end else if (state_reg == ST_ALIGN) begin
			align_cnt_reg <= align_cnt_reg + 18'h00001;
		end else begin
			align_cnt_reg <= 18'h00000;
		end
	end

	// Steps of an enable: alignment hands over to running, which opens with a low output.
	sequence seq_align_enter;
		(state_reg == ST_ALIGN) ##1 (state_reg == ST_RUN);
	endsequence

	sequence seq_first_low;
		!out_reg [*2];
	endsequence

	AST_START_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_START) |-> out_drive_n)
		else $error("Output driven during start-up.");

	AST_DISABLE_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
		(start_done && !oe_pin && float_bit) |-> (out_drive_n && !out_level))
		else $error("Disabled output with float bit set is not floating.");

	AST_DISABLE_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		(start_done && !oe_pin && !float_bit) |-> (!out_drive_n && !out_level))
		else $error("Disabled output with float bit clear is not held low.");

	AST_ACTIVE_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && oe_pin) |-> (!out_drive_n && out_level == out_reg))
		else $error("Enabled output does not show the divided clock.");

	AST_FIRST_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		seq_align_enter |-> seq_first_low)
		else $error("First pulse after enable began without a low interval.");

	AST_ALIGN_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_ALIGN) |-> (align_cnt_reg <= {1'b0, half_lim, 1'b0}))
		else $error("Enable alignment took longer than one master period.");

	AST_CODE_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(active_code_reg) |-> ($past(stab_cnt_reg) == `CODE_STABLE_TICKS &&
		$past(cand_reg) == active_code_reg))
		else $error("Select code accepted before it was stable.");

	AST_SQUARE_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && $past(state_reg) == ST_RUN && $changed(out_reg)) |->
		($past(half_tick) && $past(dcnt_reg) >= $past(cur_lim)))
		else $error("Output toggled off a half-period boundary.");

	AST_RATIO_MAP: assert property (@(posedge pclk) disable iff (!presetn)
		(active_code_reg[3] == 1'b1) |-> (new_lim == 8'((9'h001 << (3'h7 - active_code_reg[2:0]))
		- 9'h001)))
		else $error("Upper select codes do not mirror the lower ones.");

	AST_MASTER_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
		master_rise |-> ##1 (!master_rise [*8]))
		else $error("Master clock runs faster than its limit.");

	AST_START_LEAVE: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_START ##1 state_reg != ST_START) |-> code_valid_reg)
		else $error("Start-up ended without a resolved select code.");

	// Nothing high reaches the pin before the enable has been aligned to the master clock.
	AST_IDLE_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg != ST_RUN) |-> !out_level)
		else $error("Output high before the enable was aligned.");

	// Alignment loads the selected ratio and starts from a low output.
	AST_RUN_EXP: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_ALIGN && oe_level_reg && master_rise) |=>
		(state_reg == ST_RUN && cur_exp_reg == $past(new_exp) && !out_reg))
		else $error("Divider started with a ratio other than the selected one.");

	// A new ratio is adopted only where the output falls, so no period is cut short.
	AST_RUN_STEP: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && $past(state_reg) == ST_RUN && $changed(cur_exp_reg)) |->
		$fell(out_reg))
		else $error("Ratio changed in the middle of an output period.");

	// Without a synchronised enable the divider never leaves idle.
	AST_IDLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_IDLE && !oe_level_reg) |=> (state_reg == ST_IDLE))
		else $error("Divider left idle without a synchronised enable.");

endmodule // ratio_divider

// [include/ratio_divider_regs.svh]
// Register offsets, field positions, reset values and timing counts of the output divider.
`ifndef RATIO_DIVIDER_REGS_SVH
`define RATIO_DIVIDER_REGS_SVH

// Byte offsets of the three APB registers.
`define OFF_HALF_PERIOD 12'h000
`define OFF_START_LEN 12'h004
`define OFF_STATUS 12'h008

// Reset values.
`define HALF_PERIOD_RST 16'h0032
`define START_LEN_RST 10'h1f4

// Status register field positions.
`define STAT_CODE_LSB 0
`define STAT_CODE_MSB 3
`define STAT_DONE_BIT 4
`define STAT_VALID_BIT 5
`define STAT_RUN_BIT 6
`define STAT_LEVEL_BIT 7

// Clock rates in Hz and the derived shortest master half period in pclk cycles.
`define PCLK_FREQ_HZ 100000000
`define MASTER_MAX_FREQ_HZ 1000000
`define MIN_HALF_CYCLES ((`PCLK_FREQ_HZ + 2 * `MASTER_MAX_FREQ_HZ - 1) / (2 * `MASTER_MAX_FREQ_HZ))

// Master periods a new select code must hold before it is accepted.
`define CODE_STABLE_TICKS 5'h10

`endif

// [include/ratio_divider_pkg.sv]
// Types shared by the output divider design.
package ratio_divider_pkg;

	typedef logic [3:0] code_t;

	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_IDLE = 2'b01,
		ST_ALIGN = 2'b10,
		ST_RUN = 2'b11
	} div_state_t;

endpackage

// [tb/output_receiver.sv]
// Receiver of the divided output: resolves the pin and times both halves of the wave.
`timescale 1ns/10ps
module output_receiver (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic out_level,
	input wire logic out_drive_n,
	output logic pin,
	output logic [15:0] high_len,
	output logic [15:0] low_len,
	output logic [15:0] rises
);
	logic [15:0] run_len;
	logic last;
	// A floating pin shows the inverse of its last value, so no stale level looks valid.
	assign pin = out_drive_n ? ~last : out_level;
	// Count pclk cycles between driven level changes; the float gap restarts the count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= 1'b0;
			run_len <= 16'h0000;
			high_len <= 16'h0000;
			low_len <= 16'h0000;
			rises <= 16'h0000;
		end else if (out_drive_n) begin
			last <= ~last;
			run_len <= 16'h0000;
		end else if (out_level != last) begin
			last <= out_level;
			run_len <= 16'h0001;
			if (last) begin
				high_len <= run_len;
			end else begin
				low_len <= run_len;
				rises <= rises + 16'h0001;
			end
		end else begin
			run_len <= run_len + 16'h0001;
		end
	end
endmodule // output_receiver

// [tb/power_of_two_output_divider_enable_bench.sv]
// Self-checking bench for the power-of-two output divider.
`timescale 1ns/10ps
`include "ratio_divider_regs.svh"
module power_of_two_output_divider_enable_bench;
	import ratio_divider_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic oe_pin, out_level, out_drive_n, pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] ratio_select_code;
	logic [15:0] high_len, low_len, rises;
	int errors, n_compared;

	ratio_divider dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ratio_select_code(ratio_select_code), .oe_pin(oe_pin),
		.out_level(out_level), .out_drive_n(out_drive_n));
	output_receiver rx (.pclk(pclk), .presetn(presetn), .out_level(out_level),
		.out_drive_n(out_drive_n), .pin(pin), .high_len(high_len), .low_len(low_len),
		.rises(rises));

	// Free-running 100 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic close_out();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		q = prdata;
		slv = pslverr;
		if (i >= 50) begin
			errors++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Poll status until the wanted code is active and start-up is over.
	task automatic wait_code(input int c);
		logic [31:0] q;
		int i;
		i = 0;
		do begin
			apb(1'b0, `OFF_STATUS, 32'h0, q);
			i++;
		end while ((q[3:0] !== c[3:0] || q[`STAT_DONE_BIT] !== 1'b1) && i < 2000);
		if (i >= 2000) begin
			errors++;
			close_out();
		end
	endtask

	function automatic int ratio_of(input int c);
		return (c >= 8) ? (1 << (15 - c)) : (1 << c);
	endfunction

	initial begin
		logic [31:0] q;
		int c, lo, n, r0, prev, k;
		int codes[$];
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ratio_select_code = 4'h0;
		oe_pin = 1'b0;
		presetn = 1'b0;
		errors = 0;
		n_compared = 0;
		void'($urandom(32'h58403279));
		codes = '{1, 6, 9, 14, 15};
		codes.push_back(int'($urandom % 16));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		check({31'h0, out_drive_n}, 32'h1);
		@(posedge pclk);
		apb(1'b0, `OFF_HALF_PERIOD, 32'h0, q);
		check(q, {16'h0, `HALF_PERIOD_RST});
		apb(1'b0, `OFF_START_LEN, 32'h0, q);
		check(q, {22'h0, `START_LEN_RST});
		apb(1'b0, 12'h00c, 32'h0, q);
		check({q[30:0], slv}, 32'h1);
		// A half period below the limit is kept but clamped, so all timing below stays at 50.
		apb(1'b1, `OFF_HALF_PERIOD, 32'h10, q);
		apb(1'b0, `OFF_HALF_PERIOD, 32'h0, q);
		check(q, 32'h10);
		apb(1'b1, `OFF_START_LEN, 32'h2, q);
		check({31'h0, out_drive_n}, 32'h1);
		wait_code(0);
		prev = 0;
		foreach (codes[j]) begin
			c = codes[j];
			lo = (ratio_of(c) < 4) ? ratio_of(c) * 50 : 100;
			@(posedge pclk);
			ratio_select_code <= c[3:0];
			if (c != prev) begin
				repeat (1000) @(posedge pclk);
				apb(1'b0, `OFF_STATUS, 32'h0, q);
				check({28'h0, q[3:0]}, prev);
			end
			wait_code(c);
			#1;
			check({30'h0, out_drive_n, out_level}, {30'h0, c[3], 1'b0});
			@(posedge pclk);
			oe_pin <= 1'b1;
			n = 0;
			do begin
				@(posedge pclk);
				#1;
				n++;
			end while (out_level !== 1'b1 && n < lo + 300);
			if (out_level !== 1'b1) begin
				errors++;
				close_out();
			end
			check({31'h0, n >= lo && n <= lo + 210}, 32'h1);
			check({31'h0, out_drive_n}, 32'h0);
			check({31'h0, pin}, 32'h1);
			r0 = rises;
			k = 0;
			while (rises < r0 + 2 && k < ratio_of(c) * 400 + 400) begin
				@(posedge pclk);
				k++;
			end
			if (rises < r0 + 2) begin
				errors++;
				close_out();
			end
			check({16'h0, high_len}, ratio_of(c) * 50);
			check({16'h0, low_len}, ratio_of(c) * 50);
			apb(1'b0, `OFF_STATUS, 32'h0, q);
			check({29'h0, q[`STAT_RUN_BIT], q[`STAT_VALID_BIT], q[`STAT_DONE_BIT]},
				32'h7);
			@(posedge pclk);
			oe_pin <= 1'b0;
			#1;
			check({30'h0, out_drive_n, out_level}, {30'h0, c[3], 1'b0});
			prev = c;
		end
		c = (ratio_of(prev) == 1) ? 1 : 0;
		@(posedge pclk);
		oe_pin <= 1'b1;
		ratio_select_code <= c[3:0];
		wait_code(c);
		// The swap lands at a falling edge, so the third rise closes a whole new-ratio period.
		r0 = rises;
		k = 0;
		while (rises < r0 + 3 && k < ratio_of(prev) * 300 + 1000) begin
			@(posedge pclk);
			k++;
		end
		if (rises < r0 + 3) begin
			errors++;
			close_out();
		end
		check({16'h0, high_len}, ratio_of(c) * 50);
		check({16'h0, low_len}, ratio_of(c) * 50);
		close_out();
	end
endmodule // power_of_two_output_divider_enable_bench
